// ===== inc/flash_host_pkg.sv
// constants and types shared by the flash host controller files
package flash_host_pkg;
   // register byte offsets on the axi4-lite slave
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_ADDR = 5'h04;
   localparam logic [4:0] OFF_WDATA = 5'h08;
   localparam logic [4:0] OFF_STATUS = 5'h0c;
   localparam logic [4:0] OFF_RDATA = 5'h10;
   // control field positions
   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_KIND_LSB = 4;
   localparam int CTRL_RESET_BIT = 8;
   // status field positions
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_FAIL_BIT = 2;
   localparam int ST_VPP_BIT = 3;
   localparam int ST_RDY_BIT = 4;
   // data bits of the flash status word
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int FAIL_BIT = 5;
   localparam int VPP_FLAG_BIT = 3;
   localparam int LOCK_BIT = 0;
   // reset values
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] DATA_RESET = 32'h0000_0000;
   // clock and bus cycle timing
   localparam int CLK_MHZ = 25;
   localparam int STROBE_NS = 80;
   localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int RESET_PULSE_NS = 500;
   localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
   // host operation kinds
   typedef enum logic [3:0] {
      K_READ = 4'h0,
      K_WRITE = 4'h1,
      K_POLL = 4'h2,
      K_PIN_RESET = 4'h3
   } kind_t;
   // bus cycle engine phases
   typedef enum logic [3:0] {
      C_IDLE = 4'b0001,
      C_SETUP = 4'b0010,
      C_STROBE = 4'b0100,
      C_HOLD = 4'b1000
   } cyc_t;
   // controller sequence states
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_CYCLE = 5'b00010,
      S_POLL1 = 5'b00100,
      S_POLL2 = 5'b01000,
      S_RST = 5'b10000
   } seq_t;
endpackage

// ===== hdl/flash_bus_cycle.sv
// one asynchronous read or write cycle on the flash pins
`timescale 1ns/100ps
module flash_bus_cycle (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic write,
   input wire logic [20:0] addr,
   input wire logic [15:0] wdata,
   input wire logic [15:0] pin_data,
   output logic done,
   output logic [15:0] rdata,
   output logic [20:0] addr_q,
   output logic [15:0] dq_out,
   output logic dq_oe_n,
   output logic ce_n,
   output logic oe_n,
   output logic we_n
);
   flash_host_pkg::cyc_t st, next_st; // cycle phase
   logic [7:0] cnt, next_cnt; // strobe width counter
   logic next_done;
   logic [15:0] next_rdata, next_dq_out;
   logic [20:0] next_addr_q;
   logic next_dq_oe_n, next_ce_n, next_oe_n, next_we_n;
   // address is set up one cycle before the strobe so the device latches it cleanly
   always_comb begin
      next_st = st;
      next_cnt = cnt;
      next_done = 1'b0;
      next_rdata = rdata;
      next_addr_q = addr_q;
      next_dq_out = dq_out;
      next_dq_oe_n = dq_oe_n;
      next_ce_n = ce_n;
      next_oe_n = oe_n;
      next_we_n = we_n;
      unique case (st)
         flash_host_pkg::C_IDLE: begin
            if (start) begin
               next_addr_q = addr;
               next_dq_out = wdata;
               next_dq_oe_n = ~write; // drive data only on writes
               next_ce_n = 1'b0;
               next_st = flash_host_pkg::C_SETUP;
            end
         end
         flash_host_pkg::C_SETUP: begin
            next_we_n = ~dq_oe_n ? 1'b0 : 1'b1;
            next_oe_n = dq_oe_n ? 1'b0 : 1'b1;
            next_cnt = 8'(flash_host_pkg::STROBE_CYC);
            next_st = flash_host_pkg::C_STROBE;
         end
         flash_host_pkg::C_STROBE: begin
            if (cnt == 8'h00) begin
               next_rdata = pin_data; // sampled after two sync stages upstream
               next_we_n = 1'b1; // rising edge latches write data
               next_oe_n = 1'b1;
               next_st = flash_host_pkg::C_HOLD;
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         flash_host_pkg::C_HOLD: begin
            next_ce_n = 1'b1;
            next_dq_oe_n = 1'b1;
            next_done = 1'b1;
            next_st = flash_host_pkg::C_IDLE;
         end
         default: next_st = flash_host_pkg::C_IDLE;
      endcase
   end
   // register stage of the cycle engine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= flash_host_pkg::C_IDLE;
         cnt <= 8'h00;
         done <= 1'b0;
         rdata <= 16'h0000;
         addr_q <= 21'h000000;
         dq_out <= 16'h0000;
         dq_oe_n <= 1'b1;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         done <= next_done;
         rdata <= next_rdata;
         addr_q <= next_addr_q;
         dq_out <= next_dq_out;
         dq_oe_n <= next_dq_oe_n;
         ce_n <= next_ce_n;
         oe_n <= next_oe_n;
         we_n <= next_we_n;
      end
   end
endmodule

// ===== hdl/flash_host_ctrl.sv
// host controller that drives a parallel nor flash from axi4-lite registers
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
module flash_host_ctrl (
   input wire logic CORE_CLK_IN,
   input wire logic RESET_N_IN,
   // axi4-lite slave
   input wire logic [4:0] S_AWADDR_IN,
   input wire logic S_AWVALID_IN,
   output logic S_AWREADY_OUT,
   input wire logic [31:0] S_WDATA_IN,
   input wire logic [3:0] S_WSTRB_IN,
   input wire logic S_WVALID_IN,
   output logic S_WREADY_OUT,
   output logic [1:0] S_BRESP_OUT,
   output logic S_BVALID_OUT,
   input wire logic S_BREADY_IN,
   input wire logic [4:0] S_ARADDR_IN,
   input wire logic S_ARVALID_IN,
   output logic S_ARREADY_OUT,
   output logic [31:0] S_RDATA_OUT,
   output logic [1:0] S_RRESP_OUT,
   output logic S_RVALID_OUT,
   input wire logic S_RREADY_IN,
   // flash pins
   output logic [20:0] FL_ADDR_OUT,
   input wire logic [15:0] FL_DQ_IN,
   output logic [15:0] FL_DQ_OUT,
   output logic FL_DQ_OE_N_OUT,
   output logic FL_CE_N_OUT,
   output logic FL_OE_N_OUT,
   output logic FL_WE_N_OUT,
   output logic FL_RESET_N_OUT,
   input wire logic FL_RDY_IN
);
   logic rst_s1, rst_n; // reset release synchroniser
   logic [15:0] dq_s1, dq_s2; // data input synchroniser
   logic rdy_s1, rdy_s2; // ready/busy synchroniser
   // registers of our own
   logic [31:0] ctrl, next_ctrl;
   logic [31:0] addr_r, next_addr_r;
   logic [31:0] wdata_r, next_wdata_r;
   logic [15:0] rdat, next_rdat; // last data read from flash
   logic busy, next_busy; // operation in progress
   logic done, next_done; // sticky completion flag
   logic fail, next_fail; // failure flag seen in poll
   logic vpp, next_vpp; // protect supply flag seen in poll
   // axi bookkeeping
   logic aw_got, next_aw_got, w_got, next_w_got;
   logic [4:0] aw_q, next_aw_q;
   logic [31:0] w_q, next_w_q;
   logic [3:0] ws_q, next_ws_q;
   logic awr, next_awr, wr, next_wr, bv, next_bv, arr, next_arr, rv, next_rv;
   logic [1:0] br, next_br, rr, next_rr;
   logic [31:0] rd, next_rd;
   // sequencer
   flash_host_pkg::seq_t sq, next_sq;
   logic [7:0] rcnt, next_rcnt; // reset pulse counter
   logic [15:0] first_rd, next_first_rd; // first poll sample
   logic frst, next_frst; // flash reset pin level
   logic cyc_start, next_cyc_start, cyc_write, next_cyc_write;
   logic cyc_done;
   logic [15:0] cyc_rdata;
   logic [20:0] cyc_addr;
   logic [15:0] cyc_dq;
   logic cyc_dq_oe_n, cyc_ce_n, cyc_oe_n, cyc_we_n;
   logic wr_fire; // a complete register write
   logic go; // software starts an operation
   // reset release and pin synchronisers
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end
   // only the second stage is read by logic
   always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         dq_s1 <= 16'h0000;
         dq_s2 <= 16'h0000;
         rdy_s1 <= 1'b1;
         rdy_s2 <= 1'b1;
      end else begin
         dq_s1 <= FL_DQ_IN;
         dq_s2 <= dq_s1;
         rdy_s1 <= FL_RDY_IN;
         rdy_s2 <= rdy_s1;
      end
   end
   assign wr_fire = aw_got && w_got && !bv;
   assign go = wr_fire && (aw_q == flash_host_pkg::OFF_CTRL) && ws_q[0]
      && w_q[flash_host_pkg::CTRL_GO_BIT] && !busy;
   // axi4-lite slave: address and data taken in either order, one response after both
   always_comb begin
      next_aw_got = aw_got;
      next_w_got = w_got;
      next_aw_q = aw_q;
      next_w_q = w_q;
      next_ws_q = ws_q;
      next_awr = !aw_got && !awr;
      next_wr = !w_got && !wr;
      next_bv = bv;
      next_br = br;
      next_arr = !rv && !arr;
      next_rv = rv;
      next_rr = rr;
      next_rd = rd;
      next_ctrl = ctrl;
      next_addr_r = addr_r;
      next_wdata_r = wdata_r;
      if (S_AWVALID_IN && awr) begin
         next_aw_got = 1'b1;
         next_aw_q = S_AWADDR_IN;
         next_awr = 1'b0;
      end
      if (S_WVALID_IN && wr) begin
         next_w_got = 1'b1;
         next_w_q = S_WDATA_IN;
         next_ws_q = S_WSTRB_IN;
         next_wr = 1'b0;
      end
      if (wr_fire) begin
         next_bv = 1'b1;
         next_br = 2'b00;
         next_aw_got = 1'b0;
         next_w_got = 1'b0;
         // writes while an operation runs are ignored to keep the pins stable
         if (busy && aw_q != flash_host_pkg::OFF_STATUS) begin
            next_br = 2'b10;
         end else begin
            unique case (aw_q)
               flash_host_pkg::OFF_CTRL: if (ws_q[0]) next_ctrl = w_q;
               flash_host_pkg::OFF_ADDR: next_addr_r = w_q;
               flash_host_pkg::OFF_WDATA: next_wdata_r = w_q;
               flash_host_pkg::OFF_STATUS: next_br = 2'b00; // clears done below
               default: next_br = 2'b10; // unmapped
            endcase
         end
      end
      if (bv && S_BREADY_IN) next_bv = 1'b0;
      if (S_ARVALID_IN && arr) begin
         next_arr = 1'b0;
         next_rv = 1'b1;
         next_rr = 2'b00;
         unique case (S_ARADDR_IN)
            flash_host_pkg::OFF_CTRL: next_rd = ctrl;
            flash_host_pkg::OFF_ADDR: next_rd = addr_r;
            flash_host_pkg::OFF_WDATA: next_rd = wdata_r;
            flash_host_pkg::OFF_STATUS:
               next_rd = {27'h0, !rdy_s2, vpp, fail, done, busy};
            flash_host_pkg::OFF_RDATA: next_rd = {16'h0000, rdat};
            default: begin
               next_rd = 32'h0000_0000;
               next_rr = 2'b10;
            end
         endcase
      end
      if (rv && S_RREADY_IN) next_rv = 1'b0;
   end
   // axi register stage
   always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_q <= 5'h00;
         w_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         awr <= 1'b0;
         wr <= 1'b0;
         bv <= 1'b0;
         br <= 2'b00;
         arr <= 1'b0;
         rv <= 1'b0;
         rr <= 2'b00;
         rd <= 32'h0000_0000;
         ctrl <= flash_host_pkg::CTRL_RESET;
         addr_r <= flash_host_pkg::DATA_RESET;
         wdata_r <= flash_host_pkg::DATA_RESET;
      end else begin
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         aw_q <= next_aw_q;
         w_q <= next_w_q;
         ws_q <= next_ws_q;
         awr <= next_awr;
         wr <= next_wr;
         bv <= next_bv;
         br <= next_br;
         arr <= next_arr;
         rv <= next_rv;
         rr <= next_rr;
         rd <= next_rd;
         ctrl <= next_ctrl;
         addr_r <= next_addr_r;
         wdata_r <= next_wdata_r;
      end
   end
   // sequencer: single bus cycles, toggle polling, and reset pulses
   always_comb begin
      next_sq = sq;
      next_busy = busy;
      next_done = done;
      next_fail = fail;
      next_vpp = vpp;
      next_rdat = rdat;
      next_rcnt = rcnt;
      next_first_rd = first_rd;
      next_frst = frst;
      next_cyc_start = 1'b0;
      next_cyc_write = cyc_write;
      // software write to status clears done when not busy; completion in the same cycle wins
      if (wr_fire && aw_q == flash_host_pkg::OFF_STATUS && !busy) next_done = 1'b0;
      unique case (sq)
         flash_host_pkg::S_IDLE: begin
            if (go) begin
               next_busy = 1'b1;
               if (next_ctrl[flash_host_pkg::CTRL_KIND_LSB +: 4]
                  == flash_host_pkg::K_PIN_RESET) begin
                  // pin reset unlocks sectors and aborts programs
                  next_frst = 1'b0;
                  next_rcnt = 8'(flash_host_pkg::RESET_PULSE_CYC);
                  next_sq = flash_host_pkg::S_RST;
               end else begin
                  // software issues lock and exit commands as single writes
                  next_cyc_write = (w_q[flash_host_pkg::CTRL_KIND_LSB +: 4]
                     == flash_host_pkg::K_WRITE);
                  next_cyc_start = 1'b1;
                  next_fail = 1'b0;
                  next_vpp = 1'b0;
                  next_sq = (w_q[flash_host_pkg::CTRL_KIND_LSB +: 4]
                     == flash_host_pkg::K_POLL) ? flash_host_pkg::S_POLL1
                     : flash_host_pkg::S_CYCLE;
               end
            end
         end
         flash_host_pkg::S_CYCLE: begin
            if (cyc_done) begin
               next_rdat = cyc_rdata;
               next_busy = 1'b0;
               next_done = 1'b1;
               next_sq = flash_host_pkg::S_IDLE;
            end
         end
         flash_host_pkg::S_POLL1: begin
            if (cyc_done) begin
               next_first_rd = cyc_rdata;
               next_cyc_write = 1'b0;
               next_cyc_start = 1'b1;
               next_sq = flash_host_pkg::S_POLL2;
            end
         end
         flash_host_pkg::S_POLL2: begin
            if (cyc_done) begin
               next_rdat = cyc_rdata;
               // bit 6 still toggling means the operation is busy
               if (first_rd[flash_host_pkg::TOGGLE_BIT]
                  != cyc_rdata[flash_host_pkg::TOGGLE_BIT]) begin
                  // failure and supply flags are rechecked with the toggle
                  if (cyc_rdata[flash_host_pkg::FAIL_BIT]
                     || cyc_rdata[flash_host_pkg::VPP_FLAG_BIT]) begin
                     next_fail = cyc_rdata[flash_host_pkg::FAIL_BIT];
                     next_vpp = cyc_rdata[flash_host_pkg::VPP_FLAG_BIT];
                     next_busy = 1'b0;
                     next_done = 1'b1;
                     next_sq = flash_host_pkg::S_IDLE;
                  end else begin
                     next_cyc_start = 1'b1;
                     next_sq = flash_host_pkg::S_POLL1;
                  end
               end else begin
                  next_fail = cyc_rdata[flash_host_pkg::FAIL_BIT];
                  next_vpp = cyc_rdata[flash_host_pkg::VPP_FLAG_BIT];
                  next_busy = 1'b0;
                  next_done = 1'b1;
                  next_sq = flash_host_pkg::S_IDLE;
               end
            end
         end
         flash_host_pkg::S_RST: begin
            if (rcnt == 8'h00) begin
               next_frst = 1'b1;
               next_busy = 1'b0;
               next_done = 1'b1;
               next_sq = flash_host_pkg::S_IDLE;
            end else begin
               next_rcnt = rcnt - 8'h01;
            end
         end
         default: next_sq = flash_host_pkg::S_IDLE;
      endcase
   end
   // sequencer register stage
   always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         sq <= flash_host_pkg::S_IDLE;
         busy <= 1'b0;
         done <= 1'b0;
         fail <= 1'b0;
         vpp <= 1'b0;
         rdat <= 16'h0000;
         rcnt <= 8'h00;
         first_rd <= 16'h0000;
         frst <= 1'b1;
         cyc_start <= 1'b0;
         cyc_write <= 1'b0;
      end else begin
         sq <= next_sq;
         busy <= next_busy;
         done <= next_done;
         fail <= next_fail;
         vpp <= next_vpp;
         rdat <= next_rdat;
         rcnt <= next_rcnt;
         first_rd <= next_first_rd;
         frst <= next_frst;
         cyc_start <= next_cyc_start;
         cyc_write <= next_cyc_write;
      end
   end
   // pin timing engine
   flash_bus_cycle u_cycle (
      .clk(CORE_CLK_IN),
      .rst_n(rst_n),
      .start(cyc_start),
      .write(cyc_write),
      .addr(addr_r[20:0]),
      .wdata(wdata_r[15:0]),
      .pin_data(dq_s2),
      .done(cyc_done),
      .rdata(cyc_rdata),
      .addr_q(cyc_addr),
      .dq_out(cyc_dq),
      .dq_oe_n(cyc_dq_oe_n),
      .ce_n(cyc_ce_n),
      .oe_n(cyc_oe_n),
      .we_n(cyc_we_n)
   );
   assign FL_ADDR_OUT = cyc_addr;
   assign FL_DQ_OUT = cyc_dq;
   assign FL_DQ_OE_N_OUT = cyc_dq_oe_n;
   assign FL_CE_N_OUT = cyc_ce_n;
   assign FL_OE_N_OUT = cyc_oe_n;
   assign FL_WE_N_OUT = cyc_we_n;
   assign FL_RESET_N_OUT = frst;
   assign S_AWREADY_OUT = awr;
   assign S_WREADY_OUT = wr;
   assign S_BVALID_OUT = bv;
   assign S_BRESP_OUT = br;
   assign S_ARREADY_OUT = arr;
   assign S_RVALID_OUT = rv;
   assign S_RRESP_OUT = rr;
   assign S_RDATA_OUT = rd;
endmodule

// ===== verification/flash_host_ctrl_properties.sv
// port-level checker for the flash host controller, bound to its top module
`timescale 1ns/100ps
module flash_host_ctrl_properties (
   input wire logic CORE_CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic S_AWREADY_OUT,
   input wire logic [1:0] S_BRESP_OUT,
   input wire logic S_BVALID_OUT,
   input wire logic S_BREADY_IN,
   input wire logic S_ARVALID_IN,
   input wire logic S_ARREADY_OUT,
   input wire logic S_RVALID_OUT,
   input wire logic S_RREADY_IN,
   input wire logic FL_DQ_OE_N_OUT,
   input wire logic FL_CE_N_OUT,
   input wire logic FL_OE_N_OUT,
   input wire logic FL_WE_N_OUT,
   input wire logic FL_RESET_N_OUT
);
   // one clock domain, so clocking and disable are given once
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   // both strobes low at once would make the flash fight the host on dq
   strobe_excl_a: assert property (FL_WE_N_OUT || FL_OE_N_OUT)
      else $error("write and read strobes low together");
   write_drive_a: assert property (!FL_WE_N_OUT |-> !FL_CE_N_OUT && !FL_DQ_OE_N_OUT)
      else $error("write strobe without chip select or data drive");
   read_release_a: assert property (!FL_OE_N_OUT |-> FL_DQ_OE_N_OUT && !FL_CE_N_OUT)
      else $error("read strobe while host drives data");
   // strobe width is STROBE_CYC plus one cycle
   we_width_a: assert property ($fell(FL_WE_N_OUT) |-> !FL_WE_N_OUT[*3] ##1 FL_WE_N_OUT)
      else $error("write strobe width wrong");
   rst_pulse_a: assert property ($fell(FL_RESET_N_OUT) |-> ##12 !FL_RESET_N_OUT ##[1:4] FL_RESET_N_OUT)
      else $error("flash reset pulse length wrong");
   b_answer_a: assert property (S_BVALID_OUT && S_BREADY_IN |=> !S_BVALID_OUT)
      else $error("write response held after handshake");
   rvalid_time_a: assert property (S_ARVALID_IN && S_ARREADY_OUT |=> S_RVALID_OUT)
      else $error("read data late");
   r_clear_a: assert property (S_RVALID_OUT && S_RREADY_IN |=> !S_RVALID_OUT)
      else $error("read data held after handshake");
   // main scenarios reached
   cover property ($fell(FL_WE_N_OUT));
   cover property ($fell(FL_OE_N_OUT));
   cover property ($fell(FL_RESET_N_OUT));
   cover property (S_BVALID_OUT && S_BRESP_OUT == 2'b10);
endmodule
bind flash_host_ctrl flash_host_ctrl_properties u_flash_host_ctrl_properties (.*);

// ===== verification/flash_dev_model.sv
// behavioural model of the parallel nor flash on the far side of the controller
`timescale 1ns/100ps
module flash_dev_model #(
   parameter int PROG_NS = 2000 // shortened program time
) (
   input wire logic [20:0] addr_in,
   input wire logic [15:0] dq_in,
   input wire logic ce_n_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   input wire logic reset_n_in,
   input wire logic vpp_ok_in,
   output logic [15:0] dq_out,
   output logic rdy_out
);
   // command codes of this model only; single writes from software
   localparam logic [15:0] CMD_LOCK = 16'h0060;
   localparam logic [15:0] CMD_EXIT = 16'h00f0;
   logic [15:0] mem [0:31]; // small array, sector is address bit 4
   logic [1:0] lock; // one lock per sector
   logic busy, stat, fail, vflag, tog;
   logic [15:0] pd, last, st;
   logic [4:0] pa;
   initial begin
      foreach (mem[i]) mem[i] = 16'hffff;
      {lock, busy, stat, fail, vflag, tog, pd, last, pa} = '0;
   end
   // data latched on the rising write strobe
   always @(posedge we_n_in) begin
      if (reset_n_in && !ce_n_in && !busy) begin
         if (dq_in == CMD_EXIT) {stat, fail, vflag} = '0;
         else if (dq_in == CMD_LOCK) lock[addr_in[4]] = 1'b1;
         else if (lock[addr_in[4]]) {stat, fail} = 2'b11;
         else if (!vpp_ok_in) {stat, vflag} = 2'b11;
         else begin
            pa = addr_in[4:0];
            pd = dq_in;
            busy = 1'b1;
         end
      end
   end
   // program can only clear bits; read mode returns by itself
   always @(posedge busy) begin
      #PROG_NS;
      if (busy) mem[pa] = mem[pa] & pd;
      busy = 1'b0;
   end
   // reset aborts and spoils the word, and clears every lock
   always @(negedge reset_n_in) begin
      if (busy) mem[pa] = 16'h0bad;
      {busy, stat, fail, vflag, lock} = '0;
   end
   always @(negedge oe_n_in) if (busy) tog = !tog;
   always @(negedge oe_n_in) #5 last = dq_out;
   // status word; failure flags stay low while busy
   assign st = {8'h00, ~pd[7], tog, fail, 1'b0, vflag, busy, 2'b00};
   // released lines show the inverse of the last value, never a stale copy
   always_comb begin
      if (!ce_n_in && !oe_n_in && reset_n_in) dq_out = (busy || stat) ? st : mem[addr_in[4:0]];
      else dq_out = ~last;
   end
   assign rdy_out = !busy;
endmodule

// ===== verification/flash_host_ctrl_bench.sv
// self-checking bench for the flash host controller with a flash model
`timescale 1ns/100ps
module flash_host_ctrl_bench;
   logic CORE_CLK_IN, RESET_N_IN, S_AWVALID_IN, S_WVALID_IN, S_BREADY_IN, S_ARVALID_IN;
   logic S_RREADY_IN, vpp_ok;
   logic [4:0] S_AWADDR_IN, S_ARADDR_IN;
   logic [31:0] S_WDATA_IN, rd, st;
   logic [3:0] S_WSTRB_IN;
   logic [1:0] resp;
   wire logic S_AWREADY_OUT, S_WREADY_OUT, S_BVALID_OUT, S_ARREADY_OUT, S_RVALID_OUT;
   wire logic [1:0] S_BRESP_OUT, S_RRESP_OUT;
   wire logic [31:0] S_RDATA_OUT;
   wire logic [20:0] FL_ADDR_OUT;
   wire logic [15:0] FL_DQ_OUT, FL_DQ_IN, dev_dq;
   wire logic FL_DQ_OE_N_OUT, FL_CE_N_OUT, FL_OE_N_OUT, FL_WE_N_OUT, FL_RESET_N_OUT, FL_RDY_IN;
   int n_fail, tests_run;
   typedef struct packed {logic wr; logic [4:0] a; logic [31:0] d; logic [1:0] r;} row_t;
   row_t rows [0:7];
   // host drives dq only with its enable low, otherwise the flash side
   assign FL_DQ_IN = FL_DQ_OE_N_OUT ? dev_dq : FL_DQ_OUT;
   flash_host_ctrl u_flash_host_ctrl (.*);
   flash_dev_model #(.PROG_NS(2000)) u_flash_dev_model (.addr_in(FL_ADDR_OUT),
      .dq_in(FL_DQ_OUT), .ce_n_in(FL_CE_N_OUT), .oe_n_in(FL_OE_N_OUT), .we_n_in(FL_WE_N_OUT),
      .reset_n_in(FL_RESET_N_OUT), .vpp_ok_in(vpp_ok), .dq_out(dev_dq), .rdy_out(FL_RDY_IN));
   initial begin
      CORE_CLK_IN = 1'b0;
      forever #20 CORE_CLK_IN = ~CORE_CLK_IN;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // write: address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge CORE_CLK_IN);
      S_AWADDR_IN <= a;
      S_WDATA_IN <= d;
      S_AWVALID_IN <= 1'b1;
      S_WVALID_IN <= 1'b1;
      S_BREADY_IN <= 1'b1;
      while (!(aw && w)) begin
         @(posedge CORE_CLK_IN);
         aw = aw || (S_AWVALID_IN && S_AWREADY_OUT === 1'b1);
         w = w || (S_WVALID_IN && S_WREADY_OUT === 1'b1);
         S_AWVALID_IN <= !aw;
         S_WVALID_IN <= !w;
      end
      do @(posedge CORE_CLK_IN); while (S_BVALID_OUT !== 1'b1);
      resp = S_BRESP_OUT;
      S_BREADY_IN <= 1'b0;
   endtask
   task automatic axi_rd(input logic [4:0] a);
      @(posedge CORE_CLK_IN);
      S_ARADDR_IN <= a;
      S_ARVALID_IN <= 1'b1;
      S_RREADY_IN <= 1'b1;
      do @(posedge CORE_CLK_IN); while (S_ARREADY_OUT !== 1'b1);
      S_ARVALID_IN <= 1'b0;
      do @(posedge CORE_CLK_IN); while (S_RVALID_OUT !== 1'b1);
      rd = S_RDATA_OUT;
      resp = S_RRESP_OUT;
      S_RREADY_IN <= 1'b0;
   endtask
   // load address, data and go; no wait
   task automatic start_op(input logic [3:0] k, input logic [20:0] a, input logic [15:0] d);
      axi_wr(flash_host_pkg::OFF_ADDR, 32'(a));
      axi_wr(flash_host_pkg::OFF_WDATA, 32'(d));
      axi_wr(flash_host_pkg::OFF_CTRL, 32'({k, 4'h1}));
   endtask
   // poll done with a bound, then clear it; a missed done is a mismatch
   task automatic wait_done();
      st = '0;
      for (int i = 0; st[flash_host_pkg::ST_DONE_BIT] !== 1'b1 && i < 300; i++) begin
         axi_rd(flash_host_pkg::OFF_STATUS);
         st = rd;
      end
      check(st & 32'h2, 32'h2);
      axi_wr(flash_host_pkg::OFF_STATUS, 32'h0000_0000);
   endtask
   task automatic run(input logic [3:0] k, input logic [20:0] a, input logic [15:0] d);
      start_op(k, a, d);
      wait_done();
   endtask
   // program then toggle-poll; st holds the poll result
   task automatic prog(input logic [20:0] a, input logic [15:0] d);
      run(flash_host_pkg::K_WRITE, a, d);
      run(flash_host_pkg::K_POLL, a, 16'h0000);
   endtask
   task automatic read_word(input logic [20:0] a, input logic [15:0] exp);
      run(flash_host_pkg::K_READ, a, 16'h0000);
      axi_rd(flash_host_pkg::OFF_RDATA);
      check(rd, 32'(exp));
   endtask
   // watchdog well beyond the expected run length
   initial begin
      #2000000;
      n_fail++;
      print_verdict();
   end
   initial begin
      {S_AWVALID_IN, S_WVALID_IN, S_BREADY_IN, S_ARVALID_IN, S_RREADY_IN} = '0;
      {S_AWADDR_IN, S_ARADDR_IN, S_WDATA_IN} = '0;
      S_WSTRB_IN = 4'hf;
      vpp_ok = 1'b1;
      n_fail = 0;
      tests_run = 0;
      RESET_N_IN = 1'b0;
      rows = '{'{1'b0, flash_host_pkg::OFF_CTRL, flash_host_pkg::CTRL_RESET, 2'b00},
         '{1'b0, flash_host_pkg::OFF_WDATA, flash_host_pkg::DATA_RESET, 2'b00},
         '{1'b1, flash_host_pkg::OFF_ADDR, 32'h0000_0015, 2'b00},
         '{1'b0, flash_host_pkg::OFF_ADDR, 32'h0000_0015, 2'b00},
         '{1'b1, flash_host_pkg::OFF_WDATA, 32'h0000_1234, 2'b00},
         '{1'b0, flash_host_pkg::OFF_WDATA, 32'h0000_1234, 2'b00},
         '{1'b0, 5'h14, 32'h0000_0000, 2'b10},
         '{1'b1, 5'h18, 32'h0000_0000, 2'b10}};
      repeat (3) @(posedge CORE_CLK_IN);
      RESET_N_IN <= 1'b1;
      repeat (3) @(posedge CORE_CLK_IN);
      // register reset values, read-back and unmapped places
      foreach (rows[i]) begin
         if (rows[i].wr) axi_wr(rows[i].a, rows[i].d);
         else axi_rd(rows[i].a);
         check(32'(resp), 32'(rows[i].r));
         if (!rows[i].wr) check(rd, rows[i].d);
      end
      $display("test registers finished");
      // busy refuses writes; data bits 5 and 3 stay low since a settled poll takes them as flags
      start_op(flash_host_pkg::K_WRITE, 21'h3, 16'h5252);
      axi_wr(flash_host_pkg::OFF_ADDR, 32'h0000_0007);
      check(32'(resp), 32'h2);
      wait_done();
      run(flash_host_pkg::K_POLL, 21'h3, 16'h0000);
      check(st & 32'hc, 32'h0);
      read_word(21'h3, 16'h5252);
      prog(21'h3, 16'h0ff0);
      read_word(21'h3, 16'h0250);
      $display("test program finished");
      // locked sector refuses program and needs the exit command
      run(flash_host_pkg::K_WRITE, 21'h10, 16'h0060);
      prog(21'h13, 16'h0000);
      check(st & 32'h4, 32'h4);
      run(flash_host_pkg::K_WRITE, 21'h0, 16'h00f0);
      read_word(21'h13, 16'hffff);
      $display("test lockdown finished");
      // protect supply low
      vpp_ok <= 1'b0;
      prog(21'h5, 16'h0000);
      check(st & 32'h8, 32'h8);
      vpp_ok <= 1'b1;
      run(flash_host_pkg::K_WRITE, 21'h0, 16'h00f0);
      read_word(21'h5, 16'hffff);
      $display("test supply finished");
      // flash reset pulse lifts the lock
      run(flash_host_pkg::K_PIN_RESET, 21'h0, 16'h0000);
      prog(21'h13, 16'h1234);
      read_word(21'h13, 16'h1234);
      $display("test reset finished");
      print_verdict();
   end
endmodule
